//--- swr_cfg.svh
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH
// Flux reversals counted before card detect asserts
`define SWR_FLUX_DETECT 4'hF
// Card detect release delay after the last strobe
`define SWR_HOLD_MS 150
`define SWR_LINK_NS 125
`define SWR_HOLD_CYC ((`SWR_HOLD_MS * 1000000) / `SWR_LINK_NS)
`define SWR_FIFO_DEPTH 4
`define SWR_MEM_BYTES 64
// Sentinels, data bits without parity
`define SWR_START_NUM 6'h0B
`define SWR_END_NUM 6'h0F
`define SWR_START_ALPHA 6'h05
`define SWR_END_ALPHA 6'h1F
// Reset values of idle-high lines and the bit counter
`define SWR_IDLE_LINES 3'h7
`define SWR_TRIG_PRELOAD 4'hF
`endif

//--- swr_pkg.sv
`include "swr_cfg.svh"
package swr_pkg;
	typedef enum logic [2:0] {
		RD_IDLE   = 3'h1,
		RD_ACTIVE = 3'h2,
		RD_HOLD   = 3'h4
	} swr_rd_st_t;

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_SEEK  = 4'h2,
		H_STORE = 4'h4,
		H_SEND  = 4'h8
	} swr_host_st_t;

	typedef struct packed {
		swr_rd_st_t  st;
		logic [3:0]  flux;
		logic [1:0]  phase;
		logic [20:0] hold;
		logic        strobe_n;
		logic        data_n;
		logic        detect_n;
	} swr_rd_state_t;

	typedef struct packed {
		logic [2:0]                       sync1;
		logic [2:0]                       sync2;
		logic                             strb_prev;
		logic                             cd_prev;
		swr_host_st_t                     st;
		logic [3:0]                       trig;
		logic [6:0]                       chr;
		logic [2:0]                       nbit;
		logic [5:0]                       lrc;
		logic                             first;
		logic                             end_seen;
		logic                             lrc_seen;
		logic                             lrc_bad;
		logic                             par_err;
		logic                             sen_err;
		logic [9:0]                       bitptr;
		logic [6:0]                       wr;
		logic [6:0]                       rd;
		logic [6:0]                       len;
		logic [7:0]                       out_data;
		logic                             out_valid;
		logic                             done;
		logic                             err_par;
		logic                             err_lrc;
		logic                             err_sen;
		logic [`SWR_MEM_BYTES-1:0][7:0]   mem;
	} swr_host_state_t;
endpackage : swr_pkg

//--- swr_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface swr_link_if;
	logic strobe_n;
	logic data_n;
	logic card_detect_n;
	modport reader (output strobe_n, output data_n, output card_detect_n);
	modport host (input strobe_n, input data_n, input card_detect_n);
endinterface : swr_link_if
`default_nettype wire

//--- swr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "swr_cfg.svh"
// Depth must be a power of two
module swr_fifo #(
	parameter int W = 1,
	parameter int D = `SWR_FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output var  logic         in_ready,
	input  wire logic [W-1:0] in_data,
	output var  logic         out_valid,
	input  wire logic         out_ready,
	output var  logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       rd;
		logic [AW-1:0]       wr;
		logic [AW:0]         cnt;
	} swr_fifo_state_t;

	swr_fifo_state_t q;
	swr_fifo_state_t n;
	logic            push;
	logic            pop;

	assign in_ready  = q.cnt != (AW+1)'(D);
	assign out_valid = q.cnt != '0;
	assign out_data  = q.mem[q.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wr] = in_data;
			n.wr = q.wr + AW'(1);
		end
		if (pop) begin
			n.rd = q.rd + AW'(1);
		end
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule : swr_fifo
`default_nettype wire

//--- swr_reader_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "swr_cfg.svh"
module swr_reader_end
	import swr_pkg::*;
#(
	parameter int HOLD_CYC = `SWR_HOLD_CYC
) (
	input  wire logic     clk_link,
	input  wire logic     reset_n,
	input  wire logic     flux_pulse,
	input  wire logic     card_on_head,
	input  wire logic     bit_valid,
	input  wire logic     bit_value,
	output var  logic     bit_ready,
	swr_link_if.reader    link
);
	localparam logic [20:0] HOLD_LAST = 21'(HOLD_CYC - 1);

	swr_rd_state_t q;
	swr_rd_state_t n;
	logic          f_valid;
	logic          f_bit;
	logic          pop;

	swr_fifo #(.W(1), .D(`SWR_FIFO_DEPTH)) u_fifo (
		.clk       (clk_link),
		.reset_n   (reset_n),
		.in_valid  (bit_valid),
		.in_ready  (bit_ready),
		.in_data   (bit_value),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_bit)
	);

	assign link.strobe_n      = q.strobe_n;      // see R1
	assign link.data_n        = q.data_n;        // see R1
	assign link.card_detect_n = q.detect_n;      // see R1

	always_comb begin
		n = q;
		pop = 1'b0;
		case (q.st)
			RD_IDLE: begin
				pop = f_valid;                   // see R3
				if (!card_on_head) begin
					n.flux = 4'h0;
				end else if (flux_pulse) begin
					if (q.flux == `SWR_FLUX_DETECT - 4'h1) begin
						n.detect_n = 1'b0;       // see R2
						n.st = RD_ACTIVE;
						n.phase = 2'h0;
					end else begin
						n.flux = q.flux + 4'h1;
					end
				end
			end
			RD_ACTIVE: begin
				if (q.phase == 2'h0) begin
					if (f_valid) begin
						pop = 1'b1;
						n.data_n = ~f_bit;       // see R6
						n.phase = 2'h1;
					end else if (!card_on_head) begin
						n.st = RD_HOLD;
						n.hold = 21'h0;
						n.data_n = 1'b1;
					end
				end else if (q.phase == 2'h1) begin
					n.strobe_n = 1'b0;           // see R4
					n.phase = 2'h2;
				end else begin
					n.strobe_n = 1'b1;
					n.phase = 2'h0;
				end
			end
			RD_HOLD: begin
				pop = f_valid;
				if (q.hold == HOLD_LAST) begin
					n.detect_n = 1'b1;           // see R9
					n.flux = 4'h0;
					n.st = RD_IDLE;
				end else begin
					n.hold = q.hold + 21'h1;
				end
			end
			default: begin
				n.st = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.st <= RD_IDLE;
			q.strobe_n <= 1'b1;
			q.data_n <= 1'b1;
			q.detect_n <= 1'b1;
		end else begin
			q <= n;
		end
	end
endmodule : swr_reader_end
`default_nettype wire

//--- swr_host_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "swr_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - Reader lines idle high, active low
// R2 - Card detect falls after 14-15 flux reversals
// R3 - No strobes before card detect asserts
// R4 - One strobe per bit after detect
// R5 - Host samples data on strobe falling edge
// R6 - Data low means one, high zero
// R7 - Skip leading zeros until first one
// R8 - Append every bit until strobes cease; per-character mode stores no characters after the LRC character
// R9 - Detect releases about 150ms after last strobe
// R10 - On detect release check parity, LRC; deliver
// R11 - Characters assembled least significant bit first
// R12 - Packed mode stores bits across bytes
// R13 - Per-character mode: one character per byte
// R14 - Optional all-ones counter as bit trigger
// R15 - Alpha track: six bits plus odd parity
// R16 - Numeric tracks: four bits plus odd parity
// R17 - LRC even columns by XOR, odd parity
// R18 - Numeric sentinels are hex B and F
module swr_host_end
	import swr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	swr_link_if.host         link,
	input  wire logic        alpha_track,
	input  wire logic        packed_mode,
	input  wire logic        counter_trigger,
	output var  logic        out_valid,
	input  wire logic        out_ready,
	output var  logic [7:0]  out_data,
	output var  logic        done,
	output var  logic        err_parity,
	output var  logic        err_lrc,
	output var  logic        err_sentinel
);
	swr_host_state_t q;
	swr_host_state_t n;
	logic            fall;
	logic            cd_rise;
	logic            bitv;
	logic            ev;
	logic            ovf;
	logic [3:0]      trig_sum;
	logic [2:0]      w_last;
	logic [6:0]      cw;
	logic [6:0]      cm;
	logic [5:0]      cdat;
	logic [5:0]      s_start;
	logic [5:0]      s_end;
	logic            take;
	logic            fin;
	logic [7:0]      pbyte;
	logic [9:0]      plen;

	assign out_valid    = q.out_valid;
	assign out_data     = q.out_data;
	assign done         = q.done;
	assign err_parity   = q.err_par;
	assign err_lrc      = q.err_lrc;
	assign err_sentinel = q.err_sen;

	////////////////////////////////////////////////////////////////////////////
	// Bit event and character assembly
	always_comb begin
		fall = q.strb_prev & ~q.sync2[0];                // see R5
		cd_rise = ~q.cd_prev & q.sync2[2];
		bitv = ~q.sync2[1];                              // see R6
		{ovf, trig_sum} = {1'b0, q.trig} + 5'h01;        // see R14
		ev = counter_trigger ? (fall & ovf) : fall;
		w_last = alpha_track ? 3'h6 : 3'h4;
		cw = q.chr;
		cw[q.nbit] = bitv;                               // see R11
		cm = cw & (alpha_track ? 7'h7F : 7'h1F);
		cdat = alpha_track ? cm[5:0] : {2'h0, cm[3:0]};  // see R15 R16
		s_start = alpha_track ? `SWR_START_ALPHA : `SWR_START_NUM;
		s_end = alpha_track ? `SWR_END_ALPHA : `SWR_END_NUM;
		pbyte = (q.bitptr[2:0] == 3'h0) ? 8'h00 : q.mem[q.bitptr[8:3]];
		pbyte[q.bitptr[2:0]] = bitv;
		plen = q.bitptr + 10'h007;
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture state machine
	always_comb begin
		n = q;
		take = 1'b0;
		fin = 1'b0;
		n.sync1 = {link.card_detect_n, link.data_n, link.strobe_n};
		n.sync2 = q.sync1;
		n.strb_prev = q.sync2[0];
		n.cd_prev = q.sync2[2];
		n.done = 1'b0;
		if (counter_trigger && fall) begin
			n.trig = ovf ? `SWR_TRIG_PRELOAD : trig_sum;
		end
		case (q.st)
			H_IDLE: begin
				if (!q.sync2[2]) begin
					n.st = H_SEEK;
					n.chr = 7'h00;
					n.nbit = 3'h0;
					n.lrc = 6'h00;
					n.first = 1'b1;
					n.end_seen = 1'b0;
					n.lrc_seen = 1'b0;
					n.lrc_bad = 1'b0;
					n.par_err = 1'b0;
					n.sen_err = 1'b0;
					n.bitptr = 10'h000;
					n.wr = 7'h00;
					n.trig = `SWR_TRIG_PRELOAD;
				end
			end
			H_SEEK: begin
				if (cd_rise) begin
					fin = 1'b1;
				end else if (ev && bitv) begin
					n.st = H_STORE;                      // see R7
					take = 1'b1;
				end
			end
			H_STORE: begin
				if (cd_rise) begin
					fin = 1'b1;                          // see R10
				end else if (ev) begin
					take = 1'b1;                         // see R8
				end
			end
			H_SEND: begin
				if (!q.out_valid || out_ready) begin
					if (q.rd != q.len) begin
						n.out_data = q.mem[q.rd[5:0]];
						n.out_valid = 1'b1;
						n.rd = q.rd + 7'h01;
					end else begin
						n.out_valid = 1'b0;
						n.st = H_IDLE;
					end
				end
			end
			default: begin
				n.st = H_IDLE;
			end
		endcase

		if (take) begin
			if (packed_mode && !q.bitptr[9]) begin
				n.mem[q.bitptr[8:3]] = pbyte;            // see R12
				n.bitptr = q.bitptr + 10'h001;
			end
			if (q.nbit == w_last) begin
				n.nbit = 3'h0;
				n.chr = 7'h00;
				if (!q.lrc_seen) begin
					if (!(^cm)) begin
						n.par_err = 1'b1;                // see R15 R16
					end
					n.first = 1'b0;
					if (q.first && cdat != s_start) begin
						n.sen_err = 1'b1;                // see R18
					end
					if (q.end_seen) begin
						n.lrc_seen = 1'b1;
						n.lrc_bad = q.lrc != cdat;       // see R17
					end else begin
						n.lrc = q.lrc ^ cdat;            // see R17
						if (!q.first && cdat == s_end) begin
							n.end_seen = 1'b1;           // see R18
						end
					end
					if (!packed_mode && !q.wr[6]) begin
						n.mem[q.wr[5:0]] = {1'b0, cm};   // see R13
						n.wr = q.wr + 7'h01;
					end
				end
			end else begin
				n.nbit = q.nbit + 3'h1;
				n.chr = cw;
			end
		end

		if (fin) begin
			n.done = 1'b1;
			n.err_par = q.par_err;
			n.err_lrc = q.lrc_bad | ~q.lrc_seen;
			n.err_sen = q.sen_err;
			n.len = packed_mode ? plen[9:3] : q.wr;
			n.rd = 7'h00;
			if (q.par_err || q.lrc_bad || !q.lrc_seen || q.sen_err) begin
				n.st = H_IDLE;
			end else begin
				n.st = H_SEND;                           // see R10
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.sync1 <= `SWR_IDLE_LINES;
			q.sync2 <= `SWR_IDLE_LINES;
			q.strb_prev <= 1'b1;
			q.cd_prev <= 1'b1;
			q.st <= H_IDLE;
			q.trig <= `SWR_TRIG_PRELOAD;
		end else begin
			q <= n;
		end
	end
endmodule : swr_host_end
`default_nettype wire

//--- swr_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module swr_link_props #(
	parameter int HOLD_CYC = 20
) (
	input wire logic clk_link,
	input wire logic reset_n,
	input wire logic strobe_n,
	input wire logic data_n,
	input wire logic card_detect_n
);
	logic [21:0] quiet_q;
	default clocking cb @(posedge clk_link); endclocking
	default disable iff (!reset_n);
	// Link cycles since the last strobe pulse
	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			quiet_q <= '0;
		end else begin
			quiet_q <= strobe_n ? quiet_q + 22'h1 : 22'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_idle_data;
		card_detect_n |-> data_n;
	endproperty
	a_idle_data:
		assert property (p_idle_data) else $error("data low while idle");
	property p_idle_strobe;
		card_detect_n |-> strobe_n;
	endproperty
	a_idle_strobe:
		assert property (p_idle_strobe) else $error("strobe before detect");
	property p_detect_first;
		$fell(card_detect_n) |-> strobe_n && data_n;
	endproperty
	a_detect_first:
		assert property (p_detect_first) else $error("detect not first");
	property p_strobe_width;
		$fell(strobe_n) |=> strobe_n;
	endproperty
	a_strobe_width:
		assert property (p_strobe_width) else $error("strobe too long");
	property p_strobe_gap;
		$rose(strobe_n) |=> strobe_n;
	endproperty
	a_strobe_gap:
		assert property (p_strobe_gap) else $error("strobe gap too short");
	property p_data_setup;
		$fell(strobe_n) |-> $stable(data_n);
	endproperty
	a_data_setup:
		assert property (p_data_setup) else $error("data moved at strobe");
	property p_data_hold;
		!strobe_n |=> $stable(data_n);
	endproperty
	a_data_hold:
		assert property (p_data_hold) else $error("data moved in strobe");
	property p_release;
		$rose(card_detect_n) |-> quiet_q > HOLD_CYC && $past(data_n);
	endproperty
	a_release:
		assert property (p_release) else $error("detect released early");
endmodule : swr_link_props
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import swr_pkg::*;
	localparam int HOLD = 20;
	logic       clk, clk_link, reset_n, flux_pulse, card_on_head, bit_valid, bit_value;
	logic       bit_ready, alpha_track, packed_mode, counter_trigger, out_valid, out_ready;
	logic       done, err_parity, err_lrc, err_sentinel;
	logic [7:0] out_data;
	logic       sent_q[$];
	logic [7:0] exp_q[$];
	int         err_count, checks_done;
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		clk_link = 1'h0;
		#17.3;
		forever #62.5 clk_link = ~clk_link;
	end
	////////////////////////////////////////////////////////////////////////////////
	swr_link_if swr_link_if_i ();
	swr_reader_end #(.HOLD_CYC(HOLD)) swr_reader_end_i (.clk_link(clk_link), .reset_n(reset_n),
		.flux_pulse(flux_pulse), .card_on_head(card_on_head), .bit_valid(bit_valid),
		.bit_value(bit_value), .bit_ready(bit_ready), .link(swr_link_if_i.reader));
	swr_host_end swr_host_end_i (.clk(clk), .reset_n(reset_n), .link(swr_link_if_i.host),
		.alpha_track(alpha_track), .packed_mode(packed_mode), .counter_trigger(counter_trigger),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .done(done),
		.err_parity(err_parity), .err_lrc(err_lrc), .err_sentinel(err_sentinel));
	swr_link_props #(.HOLD_CYC(HOLD)) swr_link_props_i (.clk_link(clk_link), .reset_n(reset_n),
		.strobe_n(swr_link_if_i.strobe_n), .data_n(swr_link_if_i.data_n),
		.card_detect_n(swr_link_if_i.card_detect_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	// Entered and left at a falling link edge, valid held high
	task automatic send_bit(input logic b);
		bit_value = b;
		bit_valid = 1'h1;
		while (bit_ready !== 1'h1) @(negedge clk_link);
		@(negedge clk_link);
		sent_q.push_back(b);
	endtask : send_bit
	always @(negedge swr_link_if_i.strobe_n) begin
		chk("strobe per bit", 8'(sent_q.size() > 0), 8'h01);
		chk("line level", {7'h0, swr_link_if_i.data_n}, {7'h0, ~sent_q.pop_front()});
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic swipe(input logic alpha, input logic pk, input logic ctr, input int kind);
		logic [5:0]  msg[6];
		logic [7:0]  chs[6];
		logic [47:0] pkd;
		int          nb, k, c, got;
		nb = alpha ? 7 : 5;
		k = 0;
		got = 0;
		pkd = '0;
		exp_q.delete();
		if (alpha) msg = '{6'h05, 6'h21, 6'h34, 6'h13, 6'h1F, 6'h00};
		else msg = '{6'h0B, 6'h01, 6'h02, 6'h03, 6'h0F, 6'h00};
		if (kind == 3) msg[0] = alpha ? 6'h07 : 6'h0D;
		msg[5] = msg[0] ^ msg[1] ^ msg[2] ^ msg[3] ^ msg[4] ^ 6'(kind == 2);
		for (int i = 0; i < 6; i++) begin
			chs[i] = alpha ? {2'h0, ~^msg[i], msg[i]} : {3'h0, ~^msg[i][3:0], msg[i][3:0]};
			if (kind == 1 && i == 2) chs[i][nb - 1] = ~chs[i][nb - 1];
			for (int j = 0; j < nb; j++) pkd[k++] = chs[i][j];
		end
		for (int b = 0; kind == 0 && b < 6; b++) begin
			if (!pk) exp_q.push_back(chs[b]);
			else if (b < (k + 9) / 8) exp_q.push_back(pkd[8 * b +: 8]);
		end
		alpha_track = alpha;
		packed_mode = pk;
		counter_trigger = ctr;
		card_on_head = 1'h1;
		for (int i = 0; i < 15; i++) begin
			flux_pulse = 1'h1;
			@(negedge clk_link);
			flux_pulse = 1'h0;
			@(negedge clk_link);
			if (i == 13) chk("early detect", {7'h0, swr_link_if_i.card_detect_n}, 8'h01);
		end
		chk("detect", {7'h0, swr_link_if_i.card_detect_n}, 8'h00);
		repeat (4) send_bit(1'h0);
		for (int i = 0; i < 6; i++) for (int j = 0; j < nb; j++) send_bit(chs[i][j]);
		repeat (2) send_bit(1'h0);
		bit_valid = 1'h0;
		card_on_head = 1'h0;
		c = 0;
		while (done !== 1'h1 && c < 20000) begin
			@(negedge clk);
			c++;
		end
		chk("done", {7'h0, done}, 8'h01);
		chk("err_parity", {7'h0, err_parity}, 8'(kind == 1));
		chk("err_lrc", {7'h0, err_lrc}, 8'(kind == 2));
		chk("err_sentinel", {7'h0, err_sentinel}, 8'(kind == 3));
		for (c = 0; c < 64; c++) begin
			@(negedge clk);
			out_ready = c[0];
			if (out_valid === 1'h1 && out_ready) chk("out_data", out_data, exp_q[got++]);
		end
		chk("byte count", 8'(got), 8'(exp_q.size()));
		chk("out_valid drained", {7'h0, out_valid}, 8'h00);
	endtask : swipe
	initial begin
		err_count = 0;
		checks_done = 0;
		reset_n = 1'h0;
		{flux_pulse, card_on_head, bit_valid, bit_value} = 4'h0;
		{alpha_track, packed_mode, counter_trigger, out_ready} = 4'h0;
		repeat (10) @(negedge clk_link);
		reset_n = 1'h1;
		repeat (3) @(negedge clk_link);
		chk("strobe idle", {7'h0, swr_link_if_i.strobe_n}, 8'h01);
		chk("data idle", {7'h0, swr_link_if_i.data_n}, 8'h01);
		chk("detect idle", {7'h0, swr_link_if_i.card_detect_n}, 8'h01);
		chk("bit_ready", {7'h0, bit_ready}, 8'h01);
		chk("reset flags", {3'h0, out_valid, done, err_parity, err_lrc, err_sentinel}, 8'h00);
		chk("reset out_data", out_data, 8'h00);
		for (int t = 0; t < 7; t++) begin
			swipe(t == 6, t == 2, t == 1, (t > 2 && t < 6) ? t - 2 : 0);
			$display("test %0d ended, mismatches %0d", t, err_count);
			repeat (4) @(negedge clk_link);
		end
		results();
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		results();
	end
endmodule : tb
`default_nettype wire
